// file: cri_pkg.sv
package cri_pkg;

	// Reset values of the architectural state
	localparam logic [31:0] CRI_FLAG_WORD_RST  = 32'h0000_0002;
	localparam logic [31:0] CRI_IP_RST         = 32'h0000_FFF0;
	localparam logic [15:0] CRI_CODE_SEL_RST   = 16'hF000;
	localparam logic [31:0] CRI_CODE_BASE_RST  = 32'hFFFF_0000;
	localparam logic [15:0] CRI_DATA_SEL_RST   = 16'h0000;
	localparam logic [31:0] CRI_DATA_BASE_RST  = 32'h0000_0000;
	localparam logic [15:0] CRI_SEG_LIMIT_RST  = 16'hFFFF;
	localparam logic [31:0] CRI_ITAB_BASE_RST  = 32'h0000_0000;
	localparam logic [15:0] CRI_ITAB_LIMIT_RST = 16'h03FF;
	localparam logic [31:0] CRI_MSC_RST        = 32'h6000_0010;
	localparam logic [31:0] CRI_CR4_RST        = 32'h0000_0000;
	localparam logic [7:0]  CRI_CCR_RST        = 8'h00;
	localparam logic [7:0]  CRI_CONFIG_CONTROL_REG_FOUR_RST       = 8'h80;
	localparam logic [7:0]  CRI_REGION_RST     = 8'h00;
	localparam logic [31:0] CRI_DR7_RST        = 32'h0000_0400;
	localparam logic [31:0] CRI_PASS_CODE      = 32'h0000_0000;
	localparam logic [31:0] CRI_FETCH_VECTOR   = 32'hFFFF_FFF0;

	// Field positions
	localparam int CRI_MSC_PE_BIT  = 0;
	localparam int CRI_MSC_CD_BIT  = 30;
	localparam int CRI_MSC_PG_BIT  = 31;
	localparam int CRI_CONFIG_CONTROL_REG_FOUR_INDEX  = 4;
	localparam int CRI_CCR_COUNT   = 7;
	localparam int CRI_REGION_CNT  = 8;

	// Start-up delay in external clocks per multiplier, within 150..250
	localparam int CRI_DELAY_MIN   = 150;
	localparam int CRI_DELAY_MAX   = 250;
	localparam int CRI_DELAY_2X    = 150;
	localparam int CRI_DELAY_25X   = 183;
	localparam int CRI_DELAY_3X    = 216;
	localparam int CRI_DELAY_35X   = 250;
	localparam int CRI_BIST_CYCLES = 1 << 20;

	// Family code and per-multiplier identification (arbitrary values)
	localparam logic [7:0] CRI_FAMILY_CODE = 8'hA5;
	localparam logic [7:0] CRI_ID_2X       = 8'h10;
	localparam logic [7:0] CRI_ID_25X      = 8'h11;
	localparam logic [7:0] CRI_ID_3X       = 8'h12;
	localparam logic [7:0] CRI_ID_35X      = 8'h13;

	typedef enum logic [1:0] {
		CRI_MUL_2X  = 2'h0,
		CRI_MUL_25X = 2'h1,
		CRI_MUL_3X  = 2'h2,
		CRI_MUL_35X = 2'h3
	} cri_mul_t;

	typedef enum logic [1:0] {
		CRI_ST_RESET = 2'b00,
		CRI_ST_WAIT  = 2'b01,
		CRI_ST_BIST  = 2'b11,
		CRI_ST_RUN   = 2'b10
	} cri_state_t;

endpackage

// file: cri_sync.sv
`timescale 1ns/1ps
module cri_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = i_ce ? i_async : meta_reg;
		sync_next = i_ce ? meta_reg : sync_reg;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;
endmodule

// file: cri_delay.sv
`timescale 1ns/1ps
// Start-up delay counter: loads a count, then counts down to zero.
module cri_delay #(
	parameter int WIDTH = 21
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_ce,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_count,
	output logic                  o_done
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;

	// Elaboration check: the self-test count needs 21 bits
	if (WIDTH < 21) begin : g_bad_width
		$error("cri_delay: WIDTH too small for self-test count");
	end

	always_comb begin
		count_next = count_reg;
		if (i_ce) begin
			if (i_load)
				count_next = i_count;
			else if (count_reg != '0)
				count_next = count_reg - WIDTH'(1);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	// Done follows the count alone: the caller's load depends on it
	assign o_done = (count_reg == '0);
endmodule

// file: cri_reset_init.sv
`timescale 1ns/1ps
module cri_reset_init
	import cri_pkg::*;
#(
	parameter int DELAY_2X    = cri_pkg::CRI_DELAY_2X,
	parameter int DELAY_25X   = cri_pkg::CRI_DELAY_25X,
	parameter int DELAY_3X    = cri_pkg::CRI_DELAY_3X,
	parameter int DELAY_35X   = cri_pkg::CRI_DELAY_35X,
	parameter int BIST_CYCLES = cri_pkg::CRI_BIST_CYCLES
) (
	input  wire logic            i_clock,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire logic            i_cpu_reset,
	input  wire logic            i_self_test,
	input  wire logic [1:0]      i_clock_mul,
	input  wire logic            i_bist_pass,
	output logic                 o_bus_abort,
	output logic                 o_pipe_flush,
	output logic                 o_exec_enable,
	output logic                 o_cache_invalidate,
	output logic                 o_fetch_start,
	output logic [31:0]          o_fetch_addr,
	output logic                 o_real_mode,
	output logic                 o_cache_enable,
	output logic                 o_paging_enable,
	output logic [31:0]          o_accumulator_reg,
	output logic [31:0]          o_data_id_reg,
	output logic [31:0]          o_flag_word_reg,
	output logic [31:0]          o_instruction_pointer_reg,
	output logic [15:0]          o_code_segment_sel,
	output logic [31:0]          o_code_segment_base,
	output logic [15:0]          o_code_segment_limit,
	output logic [15:0]          o_data_segment_sel,
	output logic [31:0]          o_data_segment_base,
	output logic [15:0]          o_data_segment_limit,
	output logic [31:0]          o_interrupt_table_base,
	output logic [15:0]          o_interrupt_table_limit,
	output logic [31:0]          o_machine_status_ctrl,
	output logic [31:0]          o_control_reg_four,
	output logic [7*8-1:0]       o_config_control_regs,
	output logic [8*8-1:0]       o_address_region_regs,
	output logic [8*8-1:0]       o_region_control_regs,
	output logic [31:0]          o_debug_reg_seven,
	output cri_pkg::cri_state_t  o_state
);
	import cri_pkg::*;

	localparam int CW = 21;

	// Elaboration checks: delays must be at least one, self-test count must fit the shared down-counter
	if (DELAY_2X < 1 || DELAY_25X < 1 || DELAY_3X < 1 ||
	    DELAY_35X < 1) begin : g_bad_delay
		$error("cri_reset_init: start-up delay must be at least one");
	end
	if (BIST_CYCLES < 1 || BIST_CYCLES >= (1 << CW)) begin : g_bad_bist
		$error("cri_reset_init: self-test count out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [4:0] pins_sync;
	logic       reset_s;
	logic       self_test_s;
	logic [1:0] mul_s;
	logic       bist_pass_s;

	cri_sync #(
		.WIDTH (5)
	) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_async ({~i_cpu_reset, i_self_test, i_clock_mul, i_bist_pass}),
		.o_sync  (pins_sync)
	);

	// Reset travels inverted, so a cleared synchroniser reads as reset
	// held and no boot can start before the pin is seen low
	assign reset_s     = !pins_sync[4];
	assign self_test_s = pins_sync[3];
	assign mul_s       = pins_sync[2:1];
	assign bist_pass_s = pins_sync[0];

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [CW-1:0] delay_for(input logic [1:0] mul);
		unique case (cri_mul_t'(mul))
			CRI_MUL_2X:  delay_for = CW'(DELAY_2X);
			CRI_MUL_25X: delay_for = CW'(DELAY_25X);
			CRI_MUL_3X:  delay_for = CW'(DELAY_3X);
			CRI_MUL_35X: delay_for = CW'(DELAY_35X);
		endcase
	endfunction

	function automatic logic [7:0] id_for(input logic [1:0] mul);
		unique case (cri_mul_t'(mul))
			CRI_MUL_2X:  id_for = CRI_ID_2X;
			CRI_MUL_25X: id_for = CRI_ID_25X;
			CRI_MUL_3X:  id_for = CRI_ID_3X;
			CRI_MUL_35X: id_for = CRI_ID_35X;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	cri_state_t      state_reg;
	cri_state_t      state_next;
	logic            st_req_reg;
	logic            st_req_next;
	logic [1:0]      mul_reg;
	logic [1:0]      mul_next;
	logic            load;
	logic [CW-1:0]   load_count;
	logic            done;
	logic            fetch_reg;
	logic            fetch_next;

	cri_delay #(
		.WIDTH (CW)
	) u_delay (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_load  (load),
		.i_count (load_count),
		.o_done  (done)
	);

	always_comb begin
		state_next  = state_reg;
		st_req_next = st_req_reg;
		mul_next    = mul_reg;
		load        = 1'b0;
		load_count  = delay_for(mul_reg);
		fetch_next  = i_ce ? 1'b0 : fetch_reg;
		if (i_ce) begin
			// Straps are sampled while reset holds, so the last value counts
			if (reset_s) begin
				state_next  = CRI_ST_RESET;
				st_req_next = self_test_s;
				mul_next    = mul_s;
			end else begin
				unique case (state_reg)
					CRI_ST_RESET: begin
						state_next = CRI_ST_WAIT;
						load       = 1'b1;
					end
					CRI_ST_WAIT: begin
						if (done) begin
							if (st_req_reg) begin
								state_next = CRI_ST_BIST;
								load       = 1'b1;
								load_count = CW'(BIST_CYCLES);
							end else begin
								state_next = CRI_ST_RUN;
								fetch_next = 1'b1;
							end
						end
					end
					CRI_ST_BIST: begin
						if (done) begin
							state_next = CRI_ST_RUN;
							fetch_next = 1'b1;
						end
					end
					CRI_ST_RUN: state_next = CRI_ST_RUN;
				endcase
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg  <= CRI_ST_RESET;
			st_req_reg <= 1'b0;
			mul_reg    <= 2'h0;
			fetch_reg  <= 1'b0;
		end else begin
			state_reg  <= state_next;
			st_req_reg <= st_req_next;
			mul_reg    <= mul_next;
			fetch_reg  <= fetch_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Architectural state loaded during reset

	logic [31:0] acc_reg;
	logic [31:0] acc_next;
	logic [31:0] msc_reg;
	logic [31:0] msc_next;

	// Accumulator only carries meaning after self-test; else left as is
	always_comb begin
		acc_next = acc_reg;
		msc_next = msc_reg;
		if (i_ce && reset_s)
			msc_next = CRI_MSC_RST;
		if (i_ce && state_reg == CRI_ST_BIST && done)
			acc_next = bist_pass_s ? CRI_PASS_CODE : ~CRI_PASS_CODE;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_reg <= '1;
			msc_reg <= CRI_MSC_RST;
		end else begin
			acc_reg <= acc_next;
			msc_reg <= msc_next;
		end
	end

	logic [31:0] data_id_reg;
	logic [31:0] data_id_next;
	logic [31:0] flag_reg;
	logic [31:0] flag_next;
	logic [31:0] ip_reg;
	logic [31:0] ip_next;
	logic [31:0] cr4_reg;
	logic [31:0] cr4_next;
	logic [31:0] dr7_reg;
	logic [31:0] dr7_next;

	// Nothing here writes these later, so they only reload during reset
	always_comb begin
		data_id_next = data_id_reg;
		flag_next    = flag_reg;
		ip_next      = ip_reg;
		cr4_next     = cr4_reg;
		dr7_next     = dr7_reg;
		if (i_ce && reset_s) begin
			data_id_next = {16'h0000, CRI_FAMILY_CODE,
			                id_for(mul_s)};
			flag_next    = CRI_FLAG_WORD_RST;
			ip_next      = CRI_IP_RST;
			cr4_next     = CRI_CR4_RST;
			dr7_next     = CRI_DR7_RST;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_id_reg <= {16'h0000, CRI_FAMILY_CODE, CRI_ID_2X};
			flag_reg    <= CRI_FLAG_WORD_RST;
			ip_reg      <= CRI_IP_RST;
			cr4_reg     <= CRI_CR4_RST;
			dr7_reg     <= CRI_DR7_RST;
		end else begin
			data_id_reg <= data_id_next;
			flag_reg    <= flag_next;
			ip_reg      <= ip_next;
			cr4_reg     <= cr4_next;
			dr7_reg     <= dr7_next;
		end
	end

	assign o_accumulator_reg         = acc_reg;
	assign o_machine_status_ctrl     = msc_reg;
	assign o_data_id_reg             = data_id_reg;
	assign o_flag_word_reg           = flag_reg;
	assign o_instruction_pointer_reg = ip_reg;
	assign o_code_segment_sel        = CRI_CODE_SEL_RST;
	assign o_code_segment_base       = CRI_CODE_BASE_RST;
	assign o_code_segment_limit      = CRI_SEG_LIMIT_RST;
	assign o_data_segment_sel        = CRI_DATA_SEL_RST;
	assign o_data_segment_base       = CRI_DATA_BASE_RST;
	assign o_data_segment_limit      = CRI_SEG_LIMIT_RST;
	assign o_interrupt_table_base    = CRI_ITAB_BASE_RST;
	assign o_interrupt_table_limit   = CRI_ITAB_LIMIT_RST;
	assign o_control_reg_four        = cr4_reg;
	assign o_debug_reg_seven         = dr7_reg;

	genvar g;
	generate
		for (g = 0; g < CRI_CCR_COUNT; g++) begin : g_ccr
			assign o_config_control_regs[g*8 +: 8] =
				(g == CRI_CONFIG_CONTROL_REG_FOUR_INDEX) ? CRI_CONFIG_CONTROL_REG_FOUR_RST : CRI_CCR_RST;
		end
		for (g = 0; g < CRI_REGION_CNT; g++) begin : g_region
			assign o_address_region_regs[g*8 +: 8] = CRI_REGION_RST;
			assign o_region_control_regs[g*8 +: 8] = CRI_REGION_RST;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Control outputs

	// Raw pin also stops bus and execution, without synchroniser lag
	assign o_bus_abort        = i_cpu_reset || reset_s;
	assign o_pipe_flush       = o_bus_abort ||
	                            state_reg != CRI_ST_RUN;
	assign o_exec_enable      = !o_pipe_flush;
	assign o_cache_invalidate = reset_s;
	assign o_cache_enable     = !msc_reg[CRI_MSC_CD_BIT];
	assign o_paging_enable    = msc_reg[CRI_MSC_PG_BIT];
	assign o_real_mode        = !msc_reg[CRI_MSC_PE_BIT];
	assign o_fetch_start      = fetch_reg && !reset_s;
	assign o_fetch_addr       = CRI_FETCH_VECTOR;
	assign o_state            = state_reg;
endmodule

// file: cri_reset_monitor.sv
`timescale 1ns/1ps
module cri_reset_monitor
	import cri_pkg::*;
#(
	parameter int BIST_CYCLES = cri_pkg::CRI_BIST_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_cpu_reset,
	input  wire logic        o_bus_abort,
	input  wire logic        o_pipe_flush,
	input  wire logic        o_exec_enable,
	input  wire logic        o_cache_invalidate,
	input  wire logic        o_fetch_start,
	input  wire logic [31:0] o_fetch_addr,
	input  wire logic        o_real_mode,
	input  wire logic        o_cache_enable,
	input  wire logic        o_paging_enable,
	input  wire logic [31:0] o_flag_word_reg,
	input  wire logic [31:0] o_debug_reg_seven,
	input  wire logic [31:0] o_machine_status_ctrl
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic [21:0] run_cnt_reg;
	logic [21:0] run_cnt_next;
	////////////////////////////////////////////////////////////////////////
	// Saturating count of clocks since the synchronised reset fell
	always_comb begin
		run_cnt_next = run_cnt_reg;
		if (o_cache_invalidate) begin
			run_cnt_next = '0;
		end else if (run_cnt_reg != '1) begin
			run_cnt_next = run_cnt_reg + 22'h1;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_cnt_reg <= '0;
		end else begin
			run_cnt_reg <= run_cnt_next;
		end
	end
	////////////////////////////////////////////////////////////////////////
	abort_on_reset_a: assert property (i_cpu_reset |-> o_bus_abort)
		else $error("bus abort missing while reset pin high");
	quiet_in_reset_a: assert property (o_bus_abort |-> !o_exec_enable)
		else $error("execution enabled during reset");
	flush_vs_exec_a: assert property (o_exec_enable == !o_pipe_flush)
		else $error("flush and execute enable disagree");
	exec_after_delay_a: assert property (o_exec_enable |->
		run_cnt_reg >= CRI_DELAY_MIN)
		else $error("execution enabled before start-up delay");
	fetch_pulse_a: assert property (o_fetch_start |=> !o_fetch_start)
		else $error("fetch start longer than one cycle");
	fetch_vector_a: assert property ($rose(o_exec_enable) |->
		o_fetch_start && o_fetch_addr == CRI_FETCH_VECTOR)
		else $error("run entered without fetch at vector");
	start_delay_a: assert property (o_fetch_start |->
		run_cnt_reg >= CRI_DELAY_MIN &&
		run_cnt_reg <= CRI_DELAY_MAX + BIST_CYCLES + 8)
		else $error("fetch start outside delay window");
	cache_off_a: assert property (o_cache_invalidate |=>
		o_real_mode && !o_cache_enable && !o_paging_enable)
		else $error("mode, cache or paging wrong in reset");
	msc_reset_a: assert property (o_cache_invalidate |=>
		o_machine_status_ctrl == 32'h6000_0010)
		else $error("machine status control not at reset value");
	fixed_regs_a: assert property (o_flag_word_reg == 32'h0000_0002 &&
		o_debug_reg_seven == 32'h0000_0400)
		else $error("flag word or debug register wrong");
	fetch_c: cover property (o_fetch_start);
	selftest_c: cover property (o_fetch_start && run_cnt_reg > CRI_DELAY_MAX);
	abort_run_c: cover property (o_exec_enable ##1 o_bus_abort);
endmodule

// file: cri_board_reset.sv
`timescale 1ns/1ps
module cri_board_reset (
	input  wire logic       i_clock,
	input  wire logic       i_hold,
	input  wire logic [1:0] i_mul,
	input  wire logic       i_st,
	output logic            o_cpu_reset,
	output logic [1:0]      o_clock_mul,
	output logic            o_self_test
);
	initial begin
		o_cpu_reset = 1'b1;
		o_clock_mul = 2'h0;
		o_self_test = 1'b0;
	end
	// Straps change only while reset is up, so they are stable when latched
	always @(posedge i_clock) begin
		o_cpu_reset <= #1 i_hold;
		if (i_hold || o_cpu_reset) begin
			o_clock_mul <= #1 i_mul;
			o_self_test <= #1 i_st;
		end
	end
endmodule

// file: cri_reset_init_test.sv
`timescale 1ns/1ps
module cri_reset_init_test;
	import cri_pkg::*;
	localparam int BIST = 16;
	logic        i_clock, i_rst_n, hold, st, pass, cpu_rst, self_test;
	logic [1:0]  mul, mul_pin;
	logic        abort, flush, exec, inval, fetch, rmode, cen, pen;
	logic [31:0] faddr, acc, did, flg, ip, cbase, dbase, ibase, msc, cr4, dr7;
	logic [15:0] csel, clim, dsel, dlim, ilim;
	logic [55:0] config_control_regs;
	logic [63:0] address_region_regs, region_control_regs;
	cri_state_t  state;
	int          err_total, num_checks;
	cri_board_reset board (.i_clock, .i_hold(hold), .i_mul(mul), .i_st(st),
		.o_cpu_reset(cpu_rst), .o_clock_mul(mul_pin), .o_self_test(self_test));
	cri_reset_init #(.BIST_CYCLES(BIST)) uut (.i_clock, .i_rst_n,
		.i_ce(1'b1), .i_cpu_reset(cpu_rst), .i_self_test(self_test),
		.i_clock_mul(mul_pin), .i_bist_pass(pass), .o_bus_abort(abort),
		.o_pipe_flush(flush), .o_exec_enable(exec), .o_cache_invalidate(inval),
		.o_fetch_start(fetch), .o_fetch_addr(faddr), .o_real_mode(rmode),
		.o_cache_enable(cen), .o_paging_enable(pen), .o_accumulator_reg(acc),
		.o_data_id_reg(did), .o_flag_word_reg(flg),
		.o_instruction_pointer_reg(ip), .o_code_segment_sel(csel),
		.o_code_segment_base(cbase), .o_code_segment_limit(clim),
		.o_data_segment_sel(dsel), .o_data_segment_base(dbase),
		.o_data_segment_limit(dlim), .o_interrupt_table_base(ibase),
		.o_interrupt_table_limit(ilim), .o_machine_status_ctrl(msc),
		.o_control_reg_four(cr4), .o_config_control_regs(config_control_regs),
		.o_address_region_regs(address_region_regs), .o_region_control_regs(region_control_regs),
		.o_debug_reg_seven(dr7), .o_state(state));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// Full reset and boot; expected delay and id come from the multiplier
	task automatic boot(input logic [1:0] m, input logic s, input logic p,
		input int d, input logic [7:0] id);
		int n;
		mul = m;
		st = s;
		pass = p;
		hold = 1'b1;
		tick(6);
		chk({abort, flush, exec, inval, rmode, cen, pen}, 7'h6C);
		hold = 1'b0;
		tick(1);
		n = 0;
		while (fetch !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		// Board edge and two synchroniser edges precede the count
		chk(n, s ? d + BIST + 5 : d + 4);
		chk(faddr, 32'hFFFF_FFF0);
		tick(1);
		chk({fetch, exec, flush, abort}, 4'h4);
		chk(did, {16'h0000, CRI_FAMILY_CODE, id});
		if (s) begin
			chk(acc == 32'h0, p);
		end
		chk({rmode, cen, pen}, 3'h4);
		chk({flg, ip}, 64'h0000_0002_0000_FFF0);
		chk({csel, clim, cbase}, 64'hF000_FFFF_FFFF_0000);
		chk({dsel, dlim, dbase}, 64'h0000_FFFF_0000_0000);
		chk({ilim, ibase}, 48'h03FF_0000_0000);
		chk({msc, cr4}, 64'h6000_0010_0000_0000);
		chk(config_control_regs, 56'h00_00_80_00_00_00_00);
		chk(address_region_regs, 64'h0);
		chk(region_control_regs, 64'h0);
		chk(dr7, 32'h0000_0400);
	endtask
	// Reset while running: abort must follow the raw pin at once
	task automatic abort_run;
		hold = 1'b1;
		@(posedge i_clock);
		#3;
		chk(abort, 1'b1);
		tick(3);
		chk({exec, flush, state}, {2'h1, CRI_ST_RESET});
	endtask
	// Reset in mid-countdown must restart from the reset state
	task automatic abort_wait;
		hold = 1'b0;
		tick(40);
		chk({fetch, state}, {1'b0, CRI_ST_WAIT});
		hold = 1'b1;
		tick(4);
		chk({abort, exec, state}, {2'h2, CRI_ST_RESET});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	initial begin
		#(20000 * 25);
		err_total++;
		tally_and_finish();
	end
	initial begin
		i_rst_n = 1'b0;
		hold = 1'b1;
		st = 1'b0;
		pass = 1'b1;
		mul = 2'h0;
		err_total = 0;
		num_checks = 0;
		tick(16);
		i_rst_n = 1'b1;
		boot(2'h0, 1'b0, 1'b1, CRI_DELAY_2X, CRI_ID_2X);
		boot(2'h1, 1'b0, 1'b1, CRI_DELAY_25X, CRI_ID_25X);
		boot(2'h2, 1'b0, 1'b1, CRI_DELAY_3X, CRI_ID_3X);
		boot(2'h3, 1'b1, 1'b1, CRI_DELAY_35X, CRI_ID_35X);
		abort_run();
		abort_wait();
		boot(2'h1, 1'b1, 1'b0, CRI_DELAY_25X, CRI_ID_25X);
		tally_and_finish();
	end
endmodule
bind cri_reset_init cri_reset_monitor #(.BIST_CYCLES(BIST_CYCLES)) u_mon (
	.i_clock, .i_rst_n, .i_cpu_reset, .o_bus_abort, .o_pipe_flush,
	.o_exec_enable, .o_cache_invalidate, .o_fetch_start, .o_fetch_addr,
	.o_real_mode, .o_cache_enable, .o_paging_enable, .o_flag_word_reg,
	.o_debug_reg_seven, .o_machine_status_ctrl);
